// file: verilog/gpmsr_pkg.sv
// Purpose: Shared constants and types for the gigabit management status register slice.
// Assumes: Clause 22 style serial management frames, 16-bit registers, 5-bit addresses.
// Notes: Every offset and field position used by the design lives here; the only reset value here is the control field's.
package gpmsr_pkg;

  // Register data and address widths.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;

  // Register offsets on the management interface.
  localparam logic [ADDR_W-1:0] REG_GIG_CONTROL = 5'h09;
  localparam logic [ADDR_W-1:0] REG_GIG_STATUS = 5'h0A;
  localparam logic [ADDR_W-1:0] REG_EXT_STATUS = 5'h0F;

  // Stored field of the gigabit control register: bits 12:8.
  localparam int CTL_ADV_LSB = 8;
  localparam int CTL_ADV_MSB = 12;
  localparam int CTL_ADV_W = 5;
  localparam logic [CTL_ADV_W-1:0] CTL_ADV_RESET = 5'h00;
  // Bit indices inside the stored field.
  localparam int ADV_HD_IDX = 0;
  localparam int ADV_FD_IDX = 1;
  localparam int ADV_MS_VALUE_IDX = 3;
  localparam int ADV_MS_MANUAL_IDX = 4;

  // Gigabit status register layout.
  localparam int STS_FAULT_BIT = 15;
  localparam int STS_MASTER_BIT = 14;
  localparam int STS_LOCAL_BIT = 13;
  localparam int STS_REMOTE_BIT = 12;
  localparam int STS_LP_FD_BIT = 11;
  localparam int STS_LP_HD_BIT = 10;
  localparam logic [1:0] STS_RSVD = 2'h0;
  localparam int IDLE_CNT_W = 8;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_MAX = 8'hFF;

  // Extended status: 1000BASE-X bits 15:14 zero, 1000BASE-T bits 13:12 one, rest reserved zero.
  localparam logic [DATA_W-1:0] EXT_STATUS_VALUE = 16'h3000;
  // Value returned for an address this slice does not hold.
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 16'h0000;

  // Frame header after the first start bit: ST(1) OP(2) PHYAD(5) REGAD(5).
  localparam int HDR_LEN = 13;
  localparam int HDR_ST_BIT = 12;
  localparam int HDR_OP_MSB = 11;
  localparam int HDR_OP_LSB = 10;
  localparam int HDR_PHY_MSB = 9;
  localparam int HDR_PHY_LSB = 5;
  localparam int HDR_REG_MSB = 4;
  localparam int HDR_REG_LSB = 0;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Bit counter marks: last header bit, end of read data, last bit of turnaround plus write data.
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] HDR_LAST = 5'h0C;
  localparam logic [4:0] DATA_LAST = 5'h10;
  localparam logic [4:0] WR_LAST = 5'h11;

  // Frame engine states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HDR = 5'h02,
    ST_TURN = 5'h04,
    ST_READ = 5'h08,
    ST_WRITE = 5'h10
  } gpmsr_state_t;

endpackage

// file: verilog/gpmsr_idle_counter.sv
// Purpose: Saturating idle error counter with clear on status read.
// Assumes: Error, enable and clear are on i_clock; clear is a one-cycle pulse.
// Notes: A clear and a counted error in one cycle leave the count at one.
`timescale 1ns/1ps
module gpmsr_idle_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst,
  // Events.
  input wire logic i_error,
  input wire logic i_enable,
  input wire logic i_clear,
  // Count.
  output logic [WIDTH-1:0] o_count
);

  generate
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("Counter width must be 1 to 16.");
    end
  endgenerate

  localparam logic [WIDTH-1:0] CNT_MAX = '1;
  localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);

  logic [WIDTH-1:0] next_count;
  wire counted = i_error & i_enable;
  wire at_max = (o_count == CNT_MAX);

  // Clear first, then the new error, so nothing seen in the clear cycle is lost.
  assign next_count = i_clear ? (counted ? CNT_ONE : '0) :
                      (counted && !at_max) ? o_count + CNT_ONE : o_count;

  // Reset also empties the counter.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  idle_saturate_a: assert property (at_max && !i_clear |=> o_count == CNT_MAX)
    else $error("Idle counter left its ceiling.");
  idle_advance_a: assert property (counted && !i_clear && !at_max |=>
      o_count == WIDTH'($past(o_count) + 1'b1))
    else $error("Idle counter did not advance on a counted error.");
  idle_hold_a: assert property (!counted && !i_clear |=> $stable(o_count))
    else $error("Idle counter moved without a counted error.");
  idle_clear_a: assert property (i_clear |=> o_count == ($past(counted) ? CNT_ONE : '0))
    else $error("Idle counter wrong after a clearing read.");

  sat_reached_c: cover property (at_max && counted);

endmodule // gpmsr_idle_counter

// file: verilog/gpmsr_regs.sv
// Purpose: Gigabit control, gigabit status and extended status registers behind the serial management pins.
// Assumes: The management clock is slow against i_clock (at least four i_clock cycles per half period).
// Notes: Training and negotiation logic sits outside and talks to this block on i_clock.
// Functional notes
// - Control bit 9 set advertises gigabit full duplex; clear withholds it.
// - Control bit 8 is a stored half-duplex advertisement; no half-duplex gigabit link results.
// - Control bits 12:8 go out as extra local technology ability entries.
// - A master/slave fault sets status bit 15, which stays set after the fault.
// - The fault bit clears on status read, reset, negotiation done or enabled.
// - Status bit 14 shows master (one) or slave (zero) resolution.
// - Status bit 13 reads one while the local receiver works correctly.
// - Status bit 12 reads one while the remote receiver works correctly.
// - Status bits 11 and 10 show partner gigabit full and half duplex ability.
// - Status bits 7:0 count idle errors while both receivers are correct.
// - The idle error count sticks at 255 instead of wrapping.
// - The idle error count clears on status read and on reset.
// - Extended status bits 15 and 14 always read zero.
// - Extended status bit 13 reads one: gigabit full duplex capable.
// - Extended status bit 12 reads one: gigabit half duplex capable, constant.
// - Control bit 12 forces master/slave; bit 11 picks master only when forced.
`timescale 1ns/1ps
module gpmsr_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst,
  // Serial management pins.
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe_n,
  // Link training status, on i_clock.
  input wire logic i_ms_fault,
  input wire logic i_ms_master,
  input wire logic i_local_rx_ok,
  input wire logic i_remote_rx_ok,
  input wire logic i_lp_adv_fd,
  input wire logic i_lp_adv_hd,
  input wire logic i_idle_error,
  input wire logic i_an_complete,
  input wire logic i_an_enable,
  // Advertisement and configuration towards negotiation.
  output logic [gpmsr_pkg::CTL_ADV_W-1:0] o_adv_ability,
  output logic o_adv_gig_fd,
  output logic o_adv_gig_hd,
  output logic o_ms_manual,
  output logic o_ms_force_master,
  output logic o_gig_half_link_en
);

  // Equality on a register address, used for several decodes.
  function automatic logic is_reg(input logic [gpmsr_pkg::ADDR_W-1:0] addr,
                                  input logic [gpmsr_pkg::ADDR_W-1:0] target);
    is_reg = (addr == target);
  endfunction

  // Pin synchronisers and edge history.
  logic mdc_s1;
  logic mdc_s2;
  logic mdc_s3;
  logic mdio_s1;
  logic mdio_s2;

  // Frame engine.
  gpmsr_pkg::gpmsr_state_t state;
  gpmsr_pkg::gpmsr_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic next_mdio;
  logic next_oe_n;
  logic [gpmsr_pkg::HDR_LEN-1:0] hdr;
  logic [gpmsr_pkg::DATA_W-1:0] rd_shift;
  logic [gpmsr_pkg::DATA_W-1:0] next_rd_shift;
  logic [gpmsr_pkg::DATA_W-1:0] wr_shift;
  logic [gpmsr_pkg::ADDR_W-1:0] reg_sel;
  logic wr_match;

  // Register contents.
  logic [gpmsr_pkg::CTL_ADV_W-1:0] ctl_adv;
  logic [gpmsr_pkg::CTL_ADV_W-1:0] next_ctl_adv;
  logic fault;
  logic next_fault;
  logic an_en_prev;
  logic [gpmsr_pkg::IDLE_CNT_W-1:0] idle_cnt;

  // Both pins see the same two stages, so data stays aligned with the sampled edge.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1 <= i_mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= i_mdio;
      mdio_s2 <= mdio_s1;
    end
  end

  // Rising management clock edge and the data bit that goes with it.
  wire mdc_rise = mdc_s2 & ~mdc_s3;
  wire mdio_s = mdio_s2;

  // Header decode on the bit that completes it.
  wire [gpmsr_pkg::HDR_LEN-1:0] hdr_full = {hdr[gpmsr_pkg::HDR_LEN-2:0], mdio_s};
  wire [1:0] hdr_op = hdr_full[gpmsr_pkg::HDR_OP_MSB:gpmsr_pkg::HDR_OP_LSB];
  wire [gpmsr_pkg::ADDR_W-1:0] hdr_phy = hdr_full[gpmsr_pkg::HDR_PHY_MSB:gpmsr_pkg::HDR_PHY_LSB];
  wire [gpmsr_pkg::ADDR_W-1:0] hdr_reg = hdr_full[gpmsr_pkg::HDR_REG_MSB:gpmsr_pkg::HDR_REG_LSB];
  wire hdr_st_ok = hdr_full[gpmsr_pkg::HDR_ST_BIT];
  wire phy_hit = is_reg(hdr_phy, PHY_ADDR);
  wire op_valid = (hdr_op == gpmsr_pkg::OP_READ) || (hdr_op == gpmsr_pkg::OP_WRITE);
  wire hdr_done = mdc_rise && (state == gpmsr_pkg::ST_HDR) && (cnt == gpmsr_pkg::HDR_LAST);
  wire rd_load = hdr_done && hdr_st_ok && (hdr_op == gpmsr_pkg::OP_READ) && phy_hit;
  // A status read clears fault and count only after the snapshot below is taken.
  wire rd_clear = rd_load && is_reg(hdr_reg, gpmsr_pkg::REG_GIG_STATUS);

  // Write data: two turnaround bits then sixteen data bits, data is the low word.
  wire [gpmsr_pkg::DATA_W-1:0] wr_full = {wr_shift[gpmsr_pkg::DATA_W-2:0], mdio_s};
  wire wr_end = mdc_rise && (state == gpmsr_pkg::ST_WRITE) && (cnt == gpmsr_pkg::WR_LAST);
  wire wr_ctl = wr_end && wr_match && is_reg(reg_sel, gpmsr_pkg::REG_GIG_CONTROL);
  wire rd_shift_en = mdc_rise && (state == gpmsr_pkg::ST_READ) && (cnt != gpmsr_pkg::DATA_LAST);

  // Read images of the three registers; reserved bits come back as zero.
  wire [gpmsr_pkg::DATA_W-1:0] ctl_word = {{(gpmsr_pkg::DATA_W - gpmsr_pkg::CTL_ADV_MSB - 1){1'b0}},
                                           ctl_adv, {gpmsr_pkg::CTL_ADV_LSB{1'b0}}};
  wire [gpmsr_pkg::DATA_W-1:0] status_word = {fault, i_ms_master,
                                              i_local_rx_ok, i_remote_rx_ok,
                                              i_lp_adv_fd, i_lp_adv_hd, gpmsr_pkg::STS_RSVD, idle_cnt};
  wire [gpmsr_pkg::DATA_W-1:0] read_value =
    is_reg(hdr_reg, gpmsr_pkg::REG_GIG_CONTROL) ? ctl_word :
    is_reg(hdr_reg, gpmsr_pkg::REG_GIG_STATUS) ? status_word :
    is_reg(hdr_reg, gpmsr_pkg::REG_EXT_STATUS) ? gpmsr_pkg::EXT_STATUS_VALUE :
    gpmsr_pkg::RD_UNMAPPED;

  // Read shifter is loaded from the current values, then walks out most significant bit first.
  assign next_rd_shift = rd_load ? read_value :
                         rd_shift_en ? {rd_shift[gpmsr_pkg::DATA_W-2:0], 1'b0} : rd_shift;

  // Frame sequencing, advanced only on rising management clock edges.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_mdio = o_mdio;
    next_oe_n = o_mdio_oe_n;
    if (mdc_rise) begin
      case (state)
        gpmsr_pkg::ST_IDLE: begin
          // Preamble ones are skipped; the first zero is the start bit.
          if (!mdio_s) begin
            next_state = gpmsr_pkg::ST_HDR;
            next_cnt = gpmsr_pkg::CNT_ZERO;
          end
        end
        gpmsr_pkg::ST_HDR: begin
          next_cnt = cnt + gpmsr_pkg::CNT_ONE;
          if (cnt == gpmsr_pkg::HDR_LAST) begin
            next_cnt = gpmsr_pkg::CNT_ZERO;
            if (!hdr_st_ok || !op_valid) begin
              next_state = gpmsr_pkg::ST_IDLE;
            end else if (rd_load) begin
              next_state = gpmsr_pkg::ST_TURN;
            end else begin
              // Frames for other addresses are swallowed so their data is not taken as a start.
              next_state = gpmsr_pkg::ST_WRITE;
            end
          end
        end
        gpmsr_pkg::ST_TURN: begin
          next_state = gpmsr_pkg::ST_READ;
          next_mdio = 1'b0;
          next_oe_n = 1'b0;
        end
        gpmsr_pkg::ST_READ: begin
          if (cnt == gpmsr_pkg::DATA_LAST) begin
            next_state = gpmsr_pkg::ST_IDLE;
            next_mdio = 1'b1;
            next_oe_n = 1'b1;
          end else begin
            next_mdio = rd_shift[gpmsr_pkg::DATA_W-1];
            next_cnt = cnt + gpmsr_pkg::CNT_ONE;
          end
        end
        gpmsr_pkg::ST_WRITE: begin
          if (cnt == gpmsr_pkg::WR_LAST) begin
            next_state = gpmsr_pkg::ST_IDLE;
          end else begin
            next_cnt = cnt + gpmsr_pkg::CNT_ONE;
          end
        end
        default: begin
          next_state = gpmsr_pkg::ST_IDLE;
          next_mdio = 1'b1;
          next_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Frame engine registers; the data pin is released at reset.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= gpmsr_pkg::ST_IDLE;
      cnt <= gpmsr_pkg::CNT_ZERO;
      o_mdio <= 1'b1;
      o_mdio_oe_n <= 1'b1;
      rd_shift <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      o_mdio <= next_mdio;
      o_mdio_oe_n <= next_oe_n;
      rd_shift <= next_rd_shift;
    end
  end

  // Header and write data shifters plus the frame's target, kept for the write commit.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hdr <= '0;
      wr_shift <= '0;
      reg_sel <= '0;
      wr_match <= 1'b0;
    end else begin
      if (mdc_rise && state == gpmsr_pkg::ST_HDR) begin
        hdr <= hdr_full;
      end
      if (mdc_rise && state == gpmsr_pkg::ST_WRITE) begin
        wr_shift <= wr_full;
      end
      if (hdr_done) begin
        reg_sel <= hdr_reg;
        wr_match <= phy_hit && (hdr_op == gpmsr_pkg::OP_WRITE);
      end
    end
  end

  // Only bits 12:8 are stored; writes to bits 7:0 are dropped so they keep reading zero.
  assign next_ctl_adv = wr_ctl ? wr_full[gpmsr_pkg::CTL_ADV_MSB:gpmsr_pkg::CTL_ADV_LSB] : ctl_adv;

  // Control field and the outputs derived from it.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl_adv <= gpmsr_pkg::CTL_ADV_RESET;
      o_ms_force_master <= 1'b0;
      o_gig_half_link_en <= 1'b0;
    end else begin
      ctl_adv <= next_ctl_adv;
      // The chosen role only matters while manual configuration is on.
      o_ms_force_master <= next_ctl_adv[gpmsr_pkg::ADV_MS_MANUAL_IDX] &
                           next_ctl_adv[gpmsr_pkg::ADV_MS_VALUE_IDX];
      // Half duplex at gigabit may be advertised but is never allowed to form a link.
      o_gig_half_link_en <= 1'b0;
    end
  end

  // The whole stored field goes to negotiation as extra ability entries.
  assign o_adv_ability = ctl_adv;
  assign o_adv_gig_fd = ctl_adv[gpmsr_pkg::ADV_FD_IDX];
  assign o_adv_gig_hd = ctl_adv[gpmsr_pkg::ADV_HD_IDX];
  assign o_ms_manual = ctl_adv[gpmsr_pkg::ADV_MS_MANUAL_IDX];

  // Any of the clearing events drops the latched fault; a fault seen in that cycle still wins.
  wire an_en_rise = i_an_enable & ~an_en_prev;
  wire fault_clear = rd_clear | i_an_complete | an_en_rise;
  assign next_fault = i_ms_fault | (fault & ~fault_clear);

  // Latched fault and negotiation enable history.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fault <= 1'b0;
      an_en_prev <= 1'b0;
    end else begin
      fault <= next_fault;
      an_en_prev <= i_an_enable;
    end
  end

  // Idle error counter, counting only while both receivers report correct operation.
  gpmsr_idle_counter #(
    .WIDTH(gpmsr_pkg::IDLE_CNT_W)
  ) u_idle_counter (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_error(i_idle_error),
    .i_enable(i_local_rx_ok & i_remote_rx_ok),
    .i_clear(rd_clear),
    .o_count(idle_cnt)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  fault_latch_a: assert property (i_ms_fault |=> fault)
    else $error("Fault event did not set the fault bit.");
  fault_hold_a: assert property (fault && !fault_clear |=> fault)
    else $error("Fault bit dropped without a clearing event.");
  fault_clear_a: assert property (fault && fault_clear && !i_ms_fault |=> !fault)
    else $error("Fault bit survived a clearing event.");
  status_snapshot_a: assert property (rd_clear |=> rd_shift == $past(status_word))
    else $error("Status read did not return the values before its clear.");
  status_fields_a: assert property (rd_clear |=>
      rd_shift[gpmsr_pkg::STS_LOCAL_BIT] == $past(i_local_rx_ok) &&
      rd_shift[gpmsr_pkg::STS_REMOTE_BIT] == $past(i_remote_rx_ok) &&
      rd_shift[gpmsr_pkg::STS_LP_FD_BIT] == $past(i_lp_adv_fd) &&
      rd_shift[gpmsr_pkg::STS_LP_HD_BIT] == $past(i_lp_adv_hd))
    else $error("Receiver or partner ability bits read wrong.");
  master_bit_a: assert property (rd_clear |=> rd_shift[gpmsr_pkg::STS_MASTER_BIT] == $past(i_ms_master))
    else $error("Resolution bit read wrong.");
  ctl_reserved_a: assert property (rd_load && is_reg(hdr_reg, gpmsr_pkg::REG_GIG_CONTROL)
      |=> rd_shift[gpmsr_pkg::CTL_ADV_LSB-1:0] == '0)
    else $error("Reserved control bits read non-zero.");
  ext_status_a: assert property (rd_load && is_reg(hdr_reg, gpmsr_pkg::REG_EXT_STATUS)
      |=> rd_shift == gpmsr_pkg::EXT_STATUS_VALUE)
    else $error("Extended status read wrong.");
  adv_write_a: assert property (wr_ctl |=>
      o_adv_gig_fd == $past(wr_full[gpmsr_pkg::ADV_FD_IDX + gpmsr_pkg::CTL_ADV_LSB]) &&
      o_adv_ability == $past(wr_full[gpmsr_pkg::CTL_ADV_MSB:gpmsr_pkg::CTL_ADV_LSB]))
    else $error("Control write did not reach the advertisement.");
  ms_force_a: assert property (!o_ms_manual |-> !o_ms_force_master)
    else $error("Master forced while manual configuration is off.");
  no_half_link_a: assert property (!o_gig_half_link_en)
    else $error("Half duplex gigabit link enabled.");
  turn_drive_a: assert property (state == gpmsr_pkg::ST_TURN && mdc_rise |=> !o_mdio_oe_n && !o_mdio)
    else $error("Turnaround zero not driven.");
  // The pin is only driven inside a read, so a host write can never collide with it.
  drive_window_a: assert property (!o_mdio_oe_n |-> state == gpmsr_pkg::ST_READ)
    else $error("Data pin driven outside a read.");
  read_release_a: assert property (state == gpmsr_pkg::ST_READ && cnt == gpmsr_pkg::DATA_LAST && mdc_rise
      |=> o_mdio_oe_n && o_mdio)
    else $error("Data pin not released after the last read bit.");

  status_read_c: cover property (rd_clear && fault);
  ctl_write_c: cover property (wr_ctl);
  fault_on_clear_c: cover property (fault_clear && i_ms_fault);
  read_done_c: cover property (state == gpmsr_pkg::ST_READ && cnt == gpmsr_pkg::DATA_LAST && mdc_rise);

endmodule // gpmsr_regs

// file: verification/gpmsr_host_model.sv
// Purpose: Station management host that runs read and write frames on the MDC and MDIO pins.
// Assumes: MDIO has a pull-up; the bench resolves the shared line from every enable.
// Notes: MDC stands low between frames, so the device sees no edges while idle.
`timescale 1ns/1ps
module gpmsr_host_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Shared line as the host sees it.
  input wire logic i_line,
  // Host drive.
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_en
);
  initial begin
    o_mdc = 1'h0;
    o_mdio = 1'h1;
    o_mdio_en = 1'h0;
  end
  // Preamble, start, opcode, addresses, turnaround and data, MSB first; data changes while MDC is low.
  // On a read the host lets go after the register address, so the device owns the turnaround.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [33:0] f;
    f = {4'hD, op, PHY_ADDR, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int k = 33; k >= 0; k--) begin
      o_mdio_en = (op == gpmsr_pkg::OP_WRITE) || (k > 17);
      o_mdio = f[k];
      #62.5 o_mdc = 1'h1;
      if (k < 16) rd[k] = i_line; // Sampled at the rise, long before the device moves the line.
      #62.5 o_mdc = 1'h0;
    end
    o_mdio_en = 1'h0;
    #300;
  endtask
endmodule // gpmsr_host_model

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the gigabit management status register slice.
// Assumes: The host model frames every register access; status inputs change on i_clock.
// Notes: Each scenario is its own task and judges its own results.
`timescale 1ns/1ps
module tb_top;
  logic i_clock, i_rst, ms_fault, ms_master, local_ok, remote_ok, lp_fd, lp_hd, idle_err, an_done, an_en;
  logic mdc, host_d, host_en, dut_d, dut_oe_n, gig_fd, gig_hd, ms_man, ms_fm, half_en;
  logic [4:0] adv;
  logic [15:0] rv;
  wire logic line;
  int n_fail = 0;
  int total_checks = 0;
  // The pull-up wins whenever nobody enables a driver.
  assign line = !dut_oe_n ? dut_d : (host_en ? host_d : 1'h1);
  gpmsr_regs dut (.i_clock(i_clock), .i_rst(i_rst), .i_mdc(mdc), .i_mdio(line), .o_mdio(dut_d),
    .o_mdio_oe_n(dut_oe_n), .i_ms_fault(ms_fault), .i_ms_master(ms_master), .i_local_rx_ok(local_ok),
    .i_remote_rx_ok(remote_ok), .i_lp_adv_fd(lp_fd), .i_lp_adv_hd(lp_hd), .i_idle_error(idle_err),
    .i_an_complete(an_done), .i_an_enable(an_en), .o_adv_ability(adv), .o_adv_gig_fd(gig_fd),
    .o_adv_gig_hd(gig_hd), .o_ms_manual(ms_man), .o_ms_force_master(ms_fm), .o_gig_half_link_en(half_en));
  gpmsr_host_model host (.i_line(line), .o_mdc(mdc), .o_mdio(host_d), .o_mdio_en(host_en));
  // Free-running core clock.
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end
  // Comparison, report and close.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Bus cycles and stimulus helpers.
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    host.frame(gpmsr_pkg::OP_READ, a, 16'h0000, rv);
    check(rv, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] unused;
    host.frame(gpmsr_pkg::OP_WRITE, a, v, unused);
  endtask
  task automatic set_sts(input logic [4:0] v);
    @(posedge i_clock) {ms_master, local_ok, remote_ok, lp_fd, lp_hd} <= v;
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge i_clock) idle_err <= 1'h1;
      @(posedge i_clock) idle_err <= 1'h0;
    end
  endtask
  task automatic fault();
    @(posedge i_clock) ms_fault <= 1'h1;
    @(posedge i_clock) ms_fault <= 1'h0;
  endtask
  // Scenarios.
  task automatic test_reset();
    rd(gpmsr_pkg::REG_GIG_CONTROL, 16'h0000);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h0000);
    rd(gpmsr_pkg::REG_EXT_STATUS, 16'h3000);
    rd(5'h03, 16'h0000);
    $display("test reset done");
  endtask
  task automatic test_control();
    wr(gpmsr_pkg::REG_GIG_CONTROL, 16'hFFFF);
    rd(gpmsr_pkg::REG_GIG_CONTROL, 16'h1F00);
    check({6'h00, adv, gig_fd, gig_hd, ms_man, ms_fm, half_en}, 16'h03FE);
    wr(gpmsr_pkg::REG_GIG_CONTROL, 16'h0A00);
    check({6'h00, adv, gig_fd, gig_hd, ms_man, ms_fm, half_en}, 16'h0150);
    rd(gpmsr_pkg::REG_GIG_CONTROL, 16'h0A00);
    wr(gpmsr_pkg::REG_EXT_STATUS, 16'h0000);
    rd(gpmsr_pkg::REG_EXT_STATUS, 16'h3000);
    $display("test control done");
  endtask
  task automatic test_status();
    set_sts(5'h1A);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h6800);
    set_sts(5'h05);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h1400);
    $display("test status done");
  endtask
  task automatic test_fault();
    fault();
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h9400);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h1400);
    fault();
    @(posedge i_clock) an_done <= 1'h1;
    @(posedge i_clock) an_done <= 1'h0;
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h1400);
    fault();
    @(posedge i_clock) an_en <= 1'h1;
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h1400);
    @(posedge i_clock) an_en <= 1'h0;
    $display("test fault done");
  endtask
  task automatic test_counter();
    set_sts(5'h0C);
    errs(3);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h3003);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h3000);
    set_sts(5'h04);
    errs(2);
    set_sts(5'h0C);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h3000);
    errs(300);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h30FF);
    errs(2);
    fault();
    @(posedge i_clock) i_rst <= 1'h1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'h0;
    repeat (3) @(posedge i_clock);
    rd(gpmsr_pkg::REG_GIG_STATUS, 16'h3000);
    check({6'h00, adv, gig_fd, gig_hd, ms_man, ms_fm, half_en}, 16'h0000);
    $display("test counter done");
  endtask
  // Main sequence: 12-cycle reset, then every scenario.
  initial begin
    {i_rst, ms_fault, ms_master, local_ok, remote_ok, lp_fd, lp_hd, idle_err, an_done, an_en} = 10'h200;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'h0;
    repeat (3) @(posedge i_clock);
    test_reset();
    test_control();
    test_status();
    test_fault();
    test_counter();
    tally_and_finish();
  end
  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (60000) @(posedge i_clock);
    n_fail++;
    tally_and_finish();
  end
endmodule // tb_top
